// ==== verilog/bpc_channel.sv ====
`timescale 1ns/1ps
module bpc_channel
  import bpc_pkg::*;
#(
  parameter int unsigned CNT_W = BPC_CNT_W,
  parameter int unsigned PRE_W = BPC_PRE_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // configuration
  input  wire logic             pwm_mode_en,
  input  wire logic             edge_pol,
  input  wire logic             presc_en,
  input  wire logic [PRE_W-1:0] presc_div,
  input  wire logic             xfer_dis,
  input  wire logic             force_match_a,
  // buffered match values
  input  wire logic [CNT_W-1:0] duty_match_buffer,
  input  wire logic [CNT_W-1:0] period_match_buffer,
  // status and pin
  output logic [CNT_W-1:0]      duty_match_active,
  output logic [CNT_W-1:0]      period_match_active,
  output logic [CNT_W-1:0]      count_val,
  output logic                  period_tick,
  output logic                  pwm_out
);

  // package constants resized to the parameter widths
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(BPC_CNT_ONE);
  localparam logic [CNT_W-1:0] CNT_RST = CNT_W'(BPC_RST_VAL);
  localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(BPC_PRE_ONE);

  bpc_state_e       state_ff, nxt_state;
  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] duty_ff, nxt_duty;
  logic [CNT_W-1:0] per_ff, nxt_per;
  logic             out_ff, nxt_out;
  logic             tick_ff, nxt_tick;
  logic             entry;
  logic             running;
  logic             pre_tick;
  logic             at_end;
  logic             duty_hit;

  assign duty_match_active   = duty_ff;
  assign period_match_active = per_ff;
  assign count_val           = cnt_ff;
  assign period_tick         = tick_ff;
  assign pwm_out             = out_ff;

  // shared decodes
  assign entry    = (state_ff == BPC_IDLE) && pwm_mode_en;
  assign running  = (state_ff == BPC_RUN) && pwm_mode_en;
  assign pre_tick = presc_en && (pre_ff + PRE_ONE >= presc_div);
  assign at_end   = pre_tick && (cnt_ff >= per_ff);
  assign duty_hit = pre_tick && !at_end && (cnt_ff == duty_ff);

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BPC_IDLE: begin
        if (pwm_mode_en) begin
          nxt_state = BPC_RUN;
        end
      end
      BPC_RUN: begin
        // leaving the mode freezes pin and match values
        if (!pwm_mode_en) begin
          nxt_state = BPC_IDLE;
        end
      end
      default: nxt_state = BPC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= BPC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // prescaler
  always_comb begin
    nxt_pre = pre_ff;
    if (state_ff != BPC_RUN) begin
      // restart so the first period is whole
      nxt_pre = '0;
    end else if (presc_en) begin
      // >= so a lowered ratio cannot strand the count
      nxt_pre = pre_tick ? '0 : PRE_W'(pre_ff + PRE_ONE);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // period counter
  always_comb begin
    nxt_cnt = cnt_ff;
    if (entry) begin
      nxt_cnt = CNT_ONE;
    end else if (running && pre_tick) begin
      nxt_cnt = at_end ? CNT_ONE : CNT_W'(cnt_ff + CNT_ONE);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // active match values
  always_comb begin
    nxt_duty = duty_ff;
    nxt_per  = per_ff;
    if (entry || (running && at_end && !xfer_dis)) begin
      // both copied together so a period never mixes old and new
      nxt_duty = duty_match_buffer;
      nxt_per  = period_match_buffer;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_ff <= CNT_RST;
      per_ff  <= CNT_RST;
    end else begin
      duty_ff <= nxt_duty;
      per_ff  <= nxt_per;
    end
  end

  // pin and period pulse
  always_comb begin
    nxt_out  = out_ff;
    nxt_tick = 1'b0;
    if (entry) begin
      nxt_out = ~edge_pol;
    end else if (running) begin
      if (at_end) begin
        nxt_out  = ~edge_pol;
        nxt_tick = 1'b1;
      end else if (duty_hit) begin
        nxt_out = edge_pol;
      end
      if (force_match_a) begin
        nxt_out = edge_pol;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_ff  <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      out_ff  <= nxt_out;
      tick_ff <= nxt_tick;
    end
  end

  entry_level_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_IDLE && pwm_mode_en) |=> (pwm_out == ~$past(edge_pol)))
    else $error("entry level wrong");
  xfer_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && xfer_dis) |=> $stable(period_match_active))
    else $error("period changed while frozen");
  xfer_hold_duty_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && xfer_dis) |=> $stable(duty_match_active))
    else $error("duty changed while frozen");
  force_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && force_match_a) |=> (pwm_out == $past(edge_pol)))
    else $error("force match ignored");
  copy_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && $past(state_ff) == BPC_RUN && $changed(period_match_active))
    |-> period_tick)
    else $error("period copy off boundary");
  copy_duty_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && $past(state_ff) == BPC_RUN && $changed(duty_match_active))
    |-> period_tick)
    else $error("duty copy off boundary");
  no_presc_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && !presc_en && pwm_mode_en) |=> $stable(count_val))
    else $error("count ran without prescaler");
  duty_edge_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && pre_tick && !at_end && cnt_ff == duty_ff)
    |=> (pwm_out == $past(edge_pol)))
    else $error("duty edge missed");
  entry_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_IDLE && pwm_mode_en)
    |=> (count_val == CNT_ONE && period_match_active == $past(period_match_buffer)
         && duty_match_active == $past(duty_match_buffer)))
    else $error("entry load wrong");
  period_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && at_end) |=> (count_val == CNT_ONE))
    else $error("period wrap wrong");
  count_range_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && per_ff != CNT_RST) |-> (cnt_ff <= per_ff))
    else $error("count beyond period");
  presc_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == BPC_RUN && pwm_mode_en && pre_tick) |=> (pre_ff == '0))
    else $error("prescaler not restarted");

  run_c:   cover property (@(posedge clk) disable iff (!nrst) period_tick);
  force_c: cover property (@(posedge clk) disable iff (!nrst) force_match_a && pwm_mode_en);
  frz_c:   cover property (@(posedge clk) disable iff (!nrst) period_tick && xfer_dis);
  stall_c: cover property (@(posedge clk) disable iff (!nrst) state_ff == BPC_RUN && !presc_en);
  entry_c: cover property (@(posedge clk) disable iff (!nrst) state_ff == BPC_IDLE && pwm_mode_en);

endmodule : bpc_channel

// ==== verilog/bpc_pkg.sv ====
// Functional notes
// - entering output mode loads inverse edge polarity
// - duty match sets duty, period match period
// - period equals period match times prescale ratio
// - duty percent is (period minus duty) over period
// - transfer disable freezes active match values in run; entry still loads them
// - force match acts as duty comparison event
package bpc_pkg;
  localparam int unsigned BPC_CNT_W   = 16;
  localparam int unsigned BPC_PRE_W   = 8;
  localparam logic [15:0] BPC_CNT_ONE = 16'h0001;
  localparam logic [7:0]  BPC_PRE_ONE = 8'h01;
  localparam logic [15:0] BPC_RST_VAL = 16'h0000;

  typedef enum logic [1:0] {
    BPC_IDLE = 2'b00,
    BPC_RUN  = 2'b01
  } bpc_state_e;
endpackage : bpc_pkg

// ==== bench/bpc_channel_tb_top.sv ====
`timescale 1ns/1ps
module bpc_channel_tb_top
  import bpc_pkg::*;
;
  logic        clk, nrst, mode, pol, pen, xdis, frc;
  logic [7:0]  div;
  logic [15:0] dbuf, pbuf, dact, pact, cnt, len, hi;
  logic        tick, pout;
  int          n_errors = 0;
  int          num_checks = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  bpc_channel i_dut (.clk(clk), .nrst(nrst), .pwm_mode_en(mode), .edge_pol(pol),
    .presc_en(pen), .presc_div(div), .xfer_dis(xdis), .force_match_a(frc),
    .duty_match_buffer(dbuf), .period_match_buffer(pbuf), .duty_match_active(dact),
    .period_match_active(pact), .count_val(cnt), .period_tick(tick), .pwm_out(pout));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // inputs move 1 ns after the edge so the design samples settled values
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // sync to a period end, then time one whole period and its active-level part
  task measure;
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 500) begin
      step(1);
      k++;
    end
    len = 16'h0000;
    hi  = 16'h0000;
    do begin
      step(1);
      len++;
      if (pout === pol) hi++;
    end while (tick !== 1'b1 && len < 16'h01f4);
    if (k >= 500 || len >= 16'h01f4) begin
      n_errors++;
      test_done;
    end
  endtask : measure

  initial begin
    {nrst, mode, xdis, frc} = 4'h0;
    {pol, pen} = 2'b11;
    div  = 8'h01;
    dbuf = 16'h0002;
    pbuf = 16'h0004;
    step(3);
    nrst = 1'b1;
    step(1);
    chk({15'h0000, pout}, 16'h0000);
    mode = 1'b1;
    step(1);
    chk({15'h0000, pout}, 16'h0000);
    chk(cnt, 16'h0001);
    chk(pact, 16'h0004);
    chk(dact, 16'h0002);
    measure;
    chk(len, 16'h0004);
    chk(hi, 16'h0002);
    $display("entry and waveform test done");
    xdis = 1'b1;
    dbuf = 16'h0003;
    pbuf = 16'h0006;
    measure;
    chk(len, 16'h0004);
    chk(pact, 16'h0004);
    chk(dact, 16'h0002);
    xdis = 1'b0;
    step(1);
    chk(pact, 16'h0004);
    chk(dact, 16'h0002);
    measure;
    chk(pact, 16'h0006);
    chk(dact, 16'h0003);
    chk(len, 16'h0006);
    chk(hi, 16'h0003);
    $display("transfer test done");
    div = 8'h03;
    measure;
    measure;
    chk(len, 16'h0012);
    chk(hi, 16'h0009);
    chk(cnt, 16'h0001);
    pen = 1'b0;
    step(5);
    chk(cnt, 16'h0001);
    pen = 1'b1;
    frc = 1'b1;
    step(1);
    frc = 1'b0;
    chk({15'h0000, pout}, 16'h0001);
    mode = 1'b0;
    step(1);
    mode = 1'b1;
    step(1);
    chk({15'h0000, pout}, 16'h0000);
    mode = 1'b0;
    step(1);
    pol  = 1'b0;
    mode = 1'b1;
    step(1);
    chk({15'h0000, pout}, 16'h0001);
    $display("prescaler, force and polarity test done");
    test_done;
  end
endmodule : bpc_channel_tb_top
